/* hdl/pdm_port_d.sv */
// Eight-pin shared-function port with AXI4-Lite register access
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

// Contract
// - With the parallel slave port on, every pin carries its output data, driven only while psp_drive is high, regardless of direction bits.
// - With the parallel slave port on, every pin feeds its input data regardless of direction bits.
// - A low pin chosen as a comparator analog input reads as zero in the pin read value.
// - After reset pins zero to three come up as the four comparator analog inputs.
// - With the direction bit clear, pins four to seven can carry PWM channels A to D.
module pdm_port_d
  import pdm_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // AXI4-Lite write address
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [AXI_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Pins
  input  wire logic [WIDTH-1:0]      pin_in,
  output logic      [WIDTH-1:0]      pin_out,
  output logic      [WIDTH-1:0]      pin_oe,
  // Parallel slave port
  input  wire logic [WIDTH-1:0]      psp_data_out,
  input  wire logic                  psp_drive,
  output logic      [WIDTH-1:0]      psp_data_in,
  output logic                       parallel_slave_port_enable,
  // Capture/compare unit
  input  wire logic                  ccp_compare_out,
  output logic                       ccp_capture_in,
  // PWM channels
  input  wire logic                  pwm_channel_a_output,
  input  wire logic                  pwm_channel_b_output,
  input  wire logic                  pwm_channel_c_output,
  input  wire logic                  pwm_channel_d_output,
  // Comparator analog routing enables
  output logic                       comparator_one_positive_input,
  output logic                       comparator_one_negative_input,
  output logic                       comparator_two_positive_input,
  output logic                       comparator_two_negative_input
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (WIDTH != PORT_WIDTH) begin : g_width_check
    $error("pdm_port_d serves exactly eight pins");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_mapped(input logic [AXI_ADDR_W-1:0] a);
    case (a)
      OFF_LATCH, OFF_DIR, OFF_PIN,
      OFF_FUNC, OFF_ANALOG, OFF_PSP_IN: addr_mapped = 1'b1;
      default:                          addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [AXI_ADDR_W-1:0] word_addr(
    input logic [AXI_ADDR_W-1:0] a
  );
    word_addr = {a[AXI_ADDR_W-1:2], 2'b00};
  endfunction

  function automatic logic reg_hit(
    input logic                  fire,
    input logic [AXI_ADDR_W-1:0] a,
    input logic [AXI_ADDR_W-1:0] target
  );
    reg_hit = fire && (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0]      port_output_latch;
  logic [WIDTH-1:0]      pin_direction_bit;
  logic [FUNC_WIDTH-1:0] func_ctrl;
  logic [3:0]            analog_select;
  logic [WIDTH-1:0]      port_pin_read_value;

  logic                  psp_enable;
  logic                  ccp_enable;
  logic [3:0]            pwm_enable;
  logic [3:0]            pwm_value;

  assign psp_enable = func_ctrl[FUNC_PSP_EN];
  assign ccp_enable = func_ctrl[FUNC_CCP_EN];
  assign pwm_enable = func_ctrl[FUNC_PWM_LSB +: PWM_CHANNELS];
  assign pwm_value  = {pwm_channel_d_output, pwm_channel_c_output,
                       pwm_channel_b_output, pwm_channel_a_output};

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  // Address and data are held separately so either may arrive first.
  logic                  aw_full;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic                  w_full;
  logic [7:0]            w_byte;
  logic                  w_lane0;
  logic                  wr_fire;
  logic [AXI_ADDR_W-1:0] wr_addr;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign wr_fire       = aw_full && w_full && !s_axi_bvalid;
  assign wr_addr       = word_addr(aw_addr);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_full  <= 1'b0;
      w_byte  <= '0;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Write enables
  // ----------------------------------------------------------------
  // Only byte lane 0 holds data; other lanes are ignored.
  logic                  wr_take;
  logic                  latch_we;
  logic                  dir_we;
  logic                  func_we;
  logic                  analog_we;

  assign wr_take   = wr_fire && w_lane0;
  assign latch_we  = reg_hit(wr_take, wr_addr, OFF_LATCH);
  assign dir_we    = reg_hit(wr_take, wr_addr, OFF_DIR);
  assign func_we   = reg_hit(wr_take, wr_addr, OFF_FUNC);
  assign analog_we = reg_hit(wr_take, wr_addr, OFF_ANALOG);

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_output_latch <= RST_LATCH;
    end else if (latch_we) begin
      port_output_latch <= w_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_direction_bit <= RST_DIR;
    end else if (dir_we) begin
      pin_direction_bit <= w_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      func_ctrl <= RST_FUNC;
    end else if (func_we) begin
      func_ctrl <= w_byte[FUNC_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Low pins start in their comparator analog roles
      analog_select <= RST_ANALOG;
    end else if (analog_we) begin
      analog_select <= w_byte[ANALOG_PINS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [AXI_ADDR_W-1:0] rd_addr;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr       = word_addr(s_axi_araddr);

  always_comb begin
    case (rd_addr)
      OFF_LATCH:  rd_byte = port_output_latch;
      OFF_DIR:    rd_byte = pin_direction_bit;
      OFF_PIN:    rd_byte = port_pin_read_value;
      OFF_FUNC:   rd_byte = {{(8-FUNC_WIDTH){1'b0}}, func_ctrl};
      OFF_ANALOG: rd_byte = {{(8-ANALOG_PINS){1'b0}}, analog_select};
      OFF_PSP_IN: rd_byte = psp_data_in;
      default:    rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {{(AXI_DATA_W-8){1'b0}}, rd_byte};
      s_axi_rresp  <= addr_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral routing
  // ----------------------------------------------------------------
  // Routing enables are register-held, so they are clean from reset.
  assign comparator_one_positive_input = analog_select[0];
  assign comparator_one_negative_input = analog_select[1];
  assign comparator_two_positive_input = analog_select[2];
  assign comparator_two_negative_input = analog_select[3];
  assign parallel_slave_port_enable    = psp_enable;

  // ----------------------------------------------------------------
  // Pin drive and sampling
  // ----------------------------------------------------------------
  pdm_pin_mux #(
    .WIDTH (WIDTH)
  ) pdm_pin_mux_inst (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .port_output_latch (port_output_latch),
    .pin_direction_bit (pin_direction_bit),
    .psp_enable        (psp_enable),
    .psp_drive         (psp_drive),
    .psp_data_out      (psp_data_out),
    .ccp_enable        (ccp_enable),
    .ccp_compare_out   (ccp_compare_out),
    .pwm_enable        (pwm_enable),
    .pwm_value         (pwm_value),
    .pin_out           (pin_out),
    .pin_oe            (pin_oe)
  );

  pdm_read_path #(
    .WIDTH (WIDTH)
  ) pdm_read_path_inst (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .pin_in              (pin_in),
    .analog_select       (analog_select),
    .psp_enable          (psp_enable),
    .port_pin_read_value (port_pin_read_value),
    .psp_data_in         (psp_data_in),
    .ccp_capture_in      (ccp_capture_in)
  );

endmodule

/* hdl/pdm_pkg.sv */
// Shared constants for the shared-function port D block
package pdm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int PORT_WIDTH   = 8;
  localparam int ANALOG_PINS  = 4;
  localparam int PWM_CHANNELS = 4;
  localparam int PWM_PIN_BASE = 4;
  localparam int AXI_ADDR_W   = 8;
  localparam int AXI_DATA_W   = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_LATCH  = 8'h00;
  localparam logic [7:0] OFF_DIR    = 8'h04;
  localparam logic [7:0] OFF_PIN    = 8'h08;
  localparam logic [7:0] OFF_FUNC   = 8'h0C;
  localparam logic [7:0] OFF_ANALOG = 8'h10;
  localparam logic [7:0] OFF_PSP_IN = 8'h14;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LATCH  = 8'h00;
  localparam logic [7:0] RST_DIR    = 8'hFF;
  localparam logic [5:0] RST_FUNC   = 6'h00;
  localparam logic [3:0] RST_ANALOG = 4'hF;

  // ----------------------------------------------------------------
  // Function register fields
  // ----------------------------------------------------------------
  localparam int FUNC_PSP_EN  = 0;
  localparam int FUNC_CCP_EN  = 1;
  localparam int FUNC_PWM_LSB = 2;
  localparam int FUNC_WIDTH   = 6;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Source that owns a pin's driver
  typedef enum logic [1:0] {
    PDM_SRC_GPIO,
    PDM_SRC_PSP,
    PDM_SRC_PERIPH
  } pdm_src_e;

endpackage

/* hdl/pdm_pin_mux.sv */
// Output driver selection for each pin of the port
`timescale 1ns/1ps
module pdm_pin_mux
  import pdm_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Port control
  input  wire logic [WIDTH-1:0]   port_output_latch,
  input  wire logic [WIDTH-1:0]   pin_direction_bit,
  // Parallel slave port
  input  wire logic               psp_enable,
  input  wire logic               psp_drive,
  input  wire logic [WIDTH-1:0]   psp_data_out,
  // Capture/compare and PWM
  input  wire logic               ccp_enable,
  input  wire logic               ccp_compare_out,
  input  wire logic [3:0]         pwm_enable,
  input  wire logic [3:0]         pwm_value,
  // Pin drivers
  output logic      [WIDTH-1:0]   pin_out,
  output logic      [WIDTH-1:0]   pin_oe
);

  if (WIDTH != PORT_WIDTH) begin : g_width_check
    $error("pdm_pin_mux serves exactly eight pins");
  end

  // Folded so the low pins can never index past the channel vector
  function automatic int pwm_slot(input int pin);
    pwm_slot = (pin + PWM_CHANNELS - PWM_PIN_BASE) % PWM_CHANNELS;
  endfunction

  logic [WIDTH-1:0] next_pin_out;
  logic [WIDTH-1:0] next_pin_oe;
  pdm_src_e         src;

  always_comb begin
    next_pin_out = '0;
    next_pin_oe  = '0;
    src          = PDM_SRC_GPIO;
    for (int i = 0; i < WIDTH; i++) begin
      if (psp_enable) begin
        src = PDM_SRC_PSP;
      end else if (i >= PWM_PIN_BASE && !pin_direction_bit[i] &&
                   (pwm_enable[pwm_slot(i)] ||
                    (i == PWM_PIN_BASE && ccp_enable))) begin
        src = PDM_SRC_PERIPH;
      end else begin
        src = PDM_SRC_GPIO;
      end
      case (src)
        PDM_SRC_PSP: begin
          // Direction bit plays no part here
          next_pin_out[i] = psp_data_out[i];
          next_pin_oe[i]  = psp_drive;
        end
        PDM_SRC_PERIPH: begin
          // PWM channel wins over compare output on the first pin
          next_pin_out[i] = pwm_enable[pwm_slot(i)] ?
                            pwm_value[pwm_slot(i)] :
                            ccp_compare_out;
          next_pin_oe[i]  = 1'b1;
        end
        default: begin
          next_pin_out[i] = port_output_latch[i];
          next_pin_oe[i]  = !pin_direction_bit[i];
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

endmodule

/* hdl/pdm_read_path.sv */
// Pin sampling, analog masking and peripheral input feeds
`timescale 1ns/1ps
module pdm_read_path
  import pdm_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Pin level and selection
  input  wire logic [WIDTH-1:0]   pin_in,
  input  wire logic [3:0]         analog_select,
  input  wire logic               psp_enable,
  // Sampled values
  output logic      [WIDTH-1:0]   port_pin_read_value,
  output logic      [WIDTH-1:0]   psp_data_in,
  output logic                    ccp_capture_in
);

  if (WIDTH != PORT_WIDTH) begin : g_width_check
    $error("pdm_read_path serves exactly eight pins");
  end

  logic [WIDTH-1:0] analog_mask;

  assign analog_mask = {{(WIDTH-ANALOG_PINS){1'b0}}, analog_select};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      port_pin_read_value <= '0;
    end else begin
      // Analog pins read low so their input buffer level is never seen
      port_pin_read_value <= pin_in & ~analog_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      psp_data_in <= '0;
    end else begin
      psp_data_in <= psp_enable ? pin_in : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ccp_capture_in <= 1'b0;
    end else begin
      ccp_capture_in <= pin_in[PWM_PIN_BASE];
    end
  end

endmodule

/* verif/pdm_port_d_asserts.sv */
// Concurrent checks on the ports of the port D block
`timescale 1ns/1ps
module pdm_port_d_asserts
  import pdm_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins and functions
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  psp_data_out,
  input wire logic        psp_drive,
  input wire logic [7:0]  psp_data_in,
  input wire logic        parallel_slave_port_enable,
  input wire logic        ccp_capture_in,
  input wire logic        comparator_one_positive_input,
  input wire logic        comparator_one_negative_input,
  input wire logic        comparator_two_positive_input,
  input wire logic        comparator_two_negative_input
);
  logic [3:0] comp;
  assign comp = {comparator_two_negative_input, comparator_two_positive_input,
                 comparator_one_negative_input, comparator_one_positive_input};

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  // A one-edge reset may leave a stale enable in the past sample
  property p_psp_drive;
    !$past(sys_rst) && $past(parallel_slave_port_enable) |->
      pin_oe == ($past(psp_drive) ? 8'hFF : 8'h00) &&
      (!$past(psp_drive) || pin_out == $past(psp_data_out));
  endproperty
  property p_psp_in;
    !$past(sys_rst) |-> psp_data_in ==
      ($past(parallel_slave_port_enable) ? $past(pin_in) : 8'h00);
  endproperty
  property p_por;
    $past(sys_rst) |-> comp == RST_ANALOG && pin_oe == 8'h00 &&
      !parallel_slave_port_enable;
  endproperty
  property p_capture;
    !$past(sys_rst) |-> ccp_capture_in == $past(pin_in[4]);
  endproperty
  property p_b_hold;
    s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_wr_ans;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty

  a_psp_drive: assert property (p_psp_drive)
    else $error("pins do not follow the parallel slave port");
  a_psp_in: assert property (p_psp_in)
    else $error("parallel slave port input differs from pins");
  a_por: assert property (p_por)
    else $error("reset state of pins or analog routing wrong");
  a_capture: assert property (p_capture)
    else $error("capture input does not follow pin four");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before ready");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before ready");
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
  a_wr_ans: assert property (p_wr_ans)
    else $error("write answer late");
endmodule

bind pdm_port_d pdm_port_d_asserts pdm_port_d_asserts_inst (
  .clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pin_in, .pin_out, .pin_oe, .psp_data_out, .psp_drive,
  .psp_data_in, .parallel_slave_port_enable, .ccp_capture_in,
  .comparator_one_positive_input, .comparator_one_negative_input,
  .comparator_two_positive_input, .comparator_two_negative_input);

/* verif/pdm_pin_model.sv */
// Behavioural model of the board lines around the port pins
`timescale 1ns/1ps
module pdm_pin_model
  import pdm_pkg::*;
(
  // Clock
  input  wire logic [0:0] clk,
  // Device side of the pins
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Board drivers set by the bench
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // Level the device sees
  output logic      [7:0] pin_in
);
  // An undriven line toggles so a stale level can never pass for data
  logic [7:0] float_q = 8'h5A;
  always @(posedge clk) float_q <= ~float_q;
  // Board drivers sit behind series resistors, so the device wins
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & float_q);
endmodule

/* verif/pdm_port_d_bench.sv */
// Self-checking bench for the port D block
`timescale 1ns/1ps
module pdm_port_d_bench
  import pdm_pkg::*;
;
  logic        clk, sys_rst, psp_drive, parallel_slave_port_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_in, pin_out, pin_oe;
  logic [7:0]  psp_data_out, psp_data_in, ext_val, ext_en;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, ccp_compare_out, ccp_capture_in;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, pwm, comp;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        comparator_one_positive_input, comparator_one_negative_input;
  logic        comparator_two_positive_input, comparator_two_negative_input;
  int          n_mismatch, check_count;

  assign comp = {comparator_two_negative_input, comparator_two_positive_input,
                 comparator_one_negative_input, comparator_one_positive_input};

  pdm_port_d pdm_port_d_inst (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
    .psp_data_out, .psp_drive, .psp_data_in, .parallel_slave_port_enable,
    .ccp_compare_out, .ccp_capture_in, .pwm_channel_a_output(pwm[0]),
    .pwm_channel_b_output(pwm[1]), .pwm_channel_c_output(pwm[2]),
    .pwm_channel_d_output(pwm[3]), .comparator_one_positive_input,
    .comparator_one_negative_input, .comparator_two_positive_input,
    .comparator_two_negative_input);

  pdm_pin_model pdm_pin_model_inst (.clk, .pin_out, .pin_oe, .ext_val,
    .ext_en, .pin_in);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Ready is raised late on purpose so the slave has to hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b1;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(s_axi_rresp), 32'(er));
    chk("rdata", s_axi_rdata, ed);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    chk("comp", 32'(comp), 32'(RST_ANALOG));
    chk("oe", 32'(pin_oe), 32'h0);
    rd(OFF_LATCH, 32'(RST_LATCH), RESP_OKAY);
    rd(OFF_DIR, 32'(RST_DIR), RESP_OKAY);
    rd(OFF_FUNC, 32'(RST_FUNC), RESP_OKAY);
    rd(OFF_ANALOG, 32'(RST_ANALOG), RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
  endtask

  task automatic t_analog();
    @(posedge clk);
    ext_val <= 8'hFF;
    settle();
    rd(OFF_PIN, 32'hF0, RESP_OKAY);
    wr(OFF_ANALOG, 32'h5, RESP_OKAY);
    settle();
    chk("comp", 32'(comp), 32'h5);
    rd(OFF_PIN, 32'hFA, RESP_OKAY);
    wr(OFF_ANALOG, 32'h0, RESP_OKAY);
  endtask

  task automatic t_gpio();
    wr(OFF_LATCH, 32'hA5, RESP_OKAY);
    wr(OFF_DIR, 32'h0F, RESP_OKAY);
    @(posedge clk);
    ext_val <= 8'h03;
    settle();
    chk("oe", 32'(pin_oe), 32'hF0);
    chk("out", 32'(pin_out & 8'hF0), 32'hA0);
    rd(OFF_PIN, 32'hA3, RESP_OKAY);
    chk("capture", 32'(ccp_capture_in), 32'h0);
    wr(OFF_PIN, 32'hFF, RESP_OKAY);
    wr(8'h1C, 32'hFF, RESP_SLVERR);
    rd(OFF_DIR, 32'h0F, RESP_OKAY);
  endtask

  task automatic t_pwm();
    wr(OFF_FUNC, 32'h3C, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      pwm <= 4'h1 << k;
      settle();
      chk("pwm", 32'(pin_out[7:4]), 32'h1 << k);
      chk("pwm oe", 32'(pin_oe[7:4]), 32'hF);
    end
    wr(OFF_DIR, 32'hFF, RESP_OKAY);
    settle();
    chk("float", 32'(pin_oe), 32'h0);
    wr(OFF_DIR, 32'h0F, RESP_OKAY);
    wr(OFF_FUNC, 32'h02, RESP_OKAY);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      ccp_compare_out <= v[0];
      settle();
      chk("cmp", 32'({pin_oe[4], pin_out[4]}), 32'(2 + v));
    end
  endtask

  task automatic t_psp();
    wr(OFF_DIR, 32'hF0, RESP_OKAY);
    wr(OFF_FUNC, 32'h01, RESP_OKAY);
    @(posedge clk);
    psp_drive <= 1'b1;
    psp_data_out <= 8'h96;
    settle();
    chk("psp en", 32'(parallel_slave_port_enable), 32'h1);
    chk("psp oe", 32'(pin_oe), 32'hFF);
    chk("psp out", 32'(pin_out), 32'h96);
    @(posedge clk);
    psp_drive <= 1'b0;
    ext_val <= 8'h3C;
    settle();
    chk("psp oe", 32'(pin_oe), 32'h00);
    chk("psp in", 32'(psp_data_in), 32'h3C);
    chk("capture", 32'(ccp_capture_in), 32'h1);
    wr(OFF_FUNC, 32'h00, RESP_OKAY);
    settle();
    chk("psp in", 32'(psp_data_in), 32'h00);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, psp_drive, ccp_compare_out} = '0;
    s_axi_wstrb = 4'hF;
    pwm = 4'h0;
    psp_data_out = 8'h00;
    ext_val = 8'h00;
    ext_en = 8'hFF;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    settle();
    t_reset();
    t_analog();
    t_gpio();
    t_pwm();
    t_psp();
    final_report();
  end
endmodule
